// file: rtl/scc_top.sv
/*
 * System clock source control: glitch-free source switching, main
 * oscillator frequency and trim, crystal load capacitance, low-speed
 * calibration, flash wait states, peripheral dividers, watchdog source.
 * Assumes oscillator presence/tick inputs synchronous to core_clk.
 */
//
// Contract
// - Change clock source without glitch or shortened period.
// - Synchronise every select change so switching path never goes metastable.
// - Five sources: main, low-speed, fast crystal, watch crystal, pin.
// - Main oscillator is primary source, 24 MHz by default.
// - Main oscillator programmable 3 to 48 MHz in 1 MHz steps.
// - Load factory trim from latches; flash trim may correct drift.
// - Low-speed oscillator keeps running in deep sleep.
// - Low-speed counters measurable against main oscillator for calibration.
// - Fast crystal clocks radio when active; selectable as system clock.
// - Programmable fast crystal load capacitance for frequency trim.
// - Watch crystal feeds radio sleep clock for interval wakeups.
// - Two flash wait states at 48 MHz, one at 24 MHz.
// - Twelve peripheral dividers: ten 16-bit integer, two fractional.
// - Analog clock edges lead digital divided clock edges.
// - Watchdog clocked by low-speed or watch crystal oscillator.
`timescale 1ns/1ps
`default_nettype none

module scc_top #(
	parameter int unsigned SYNC_LEN = scc_pkg::SCC_SYNC_LEN
) (
	input  wire logic                             core_clk,
	input  wire logic                             reset,
	input  wire scc_pkg::scc_bus_t                bus,
	output logic [31:0]                           rdata,
	input  wire logic [scc_pkg::SCC_NUM_SRC-1:0]  src_tick,
	input  wire logic [scc_pkg::SCC_TRM_W-1:0]    trim_latches,
	input  wire logic                             deep_sleep,
	input  wire logic                             radio_sleep,
	output logic                                  high_freq_clock_en,
	output logic [2:0]                            high_freq_src,
	output logic [scc_pkg::SCC_FRQ_W-1:0]         main_internal_osc_frq,
	output logic [scc_pkg::SCC_TRM_W-1:0]         main_internal_osc_trim,
	output logic [scc_pkg::SCC_CAP_W-1:0]         fast_crystal_osc_cap,
	output logic                                  low_speed_internal_osc_on,
	output logic                                  radio_subsystem_clk_en,
	output logic [1:0]                            flash_wait_states,
	output logic                                  analog_clk_en,
	output logic [scc_pkg::SCC_NUM_DIV-1:0]       periph_clk_en,
	output logic                                  wdt_clk_en
);

	initial begin
		if (SYNC_LEN < 2)
			$error("SYNC_LEN must be at least two");
	end

	// ==========================================================
	// Software registers
	// ==========================================================
	scc_pkg::scc_src_t                 sel_reg;
	logic [scc_pkg::SCC_FRQ_W-1:0]     frq_reg;
	logic [scc_pkg::SCC_TRM_W-1:0]     trm_reg;
	logic                              trm_flash_reg;
	logic [scc_pkg::SCC_CAP_W-1:0]     cap_reg;
	logic [scc_pkg::SCC_CAL_W-1:0]     cal_len_reg;
	logic [scc_pkg::SCC_CAL_W-1:0]     cal_cnt_reg;
	logic [scc_pkg::SCC_CAL_W-1:0]     cal_win_reg;
	logic                              cal_busy_reg;
	logic [3:0]                        div_idx_reg;
	logic [scc_pkg::SCC_DIV_W-1:0]     div_reg [scc_pkg::SCC_NUM_DIV];
	logic [scc_pkg::SCC_FRAC_W-1:0]    frac_reg [scc_pkg::SCC_NUM_FRAC];
	logic                              wdt_watch_reg;
	logic                              wr_ok;

	// Frequency value is checked before it lands
	function automatic logic frq_legal(input logic [31:0] v);
		frq_legal = v[5:0] >= scc_pkg::SCC_FRQ_MIN
			&& v[5:0] <= scc_pkg::SCC_FRQ_MAX && v[31:6] == '0;
	endfunction

	assign wr_ok = bus.wr;

	// Select, frequency, trim, capacitance, watchdog source
	always_ff @(posedge core_clk) begin
		if (reset) begin
			sel_reg       <= scc_pkg::SCC_SRC_MAIN;
			frq_reg       <= scc_pkg::SCC_FRQ_RESET;
			trm_flash_reg <= 1'b0;
			cap_reg       <= scc_pkg::SCC_CAP_RESET;
			wdt_watch_reg <= 1'b0;
			trm_reg       <= '0;
		end else if (wr_ok) begin
			case (bus.addr)
			scc_pkg::SCC_REG_SRC_SEL: begin
				// Codes beyond the five sources are dropped
				if (bus.wdata[2:0] <= 3'h4)
					sel_reg <= scc_pkg::scc_src_t'(bus.wdata[2:0]);
			end
			scc_pkg::SCC_REG_MAIN_FRQ: begin
				if (frq_legal(bus.wdata))
					frq_reg <= bus.wdata[5:0];
			end
			scc_pkg::SCC_REG_MAIN_TRM: begin
				trm_reg       <= bus.wdata[7:0];
				trm_flash_reg <= bus.wdata[8];
			end
			scc_pkg::SCC_REG_FAST_CAP:
				cap_reg <= bus.wdata[7:0];
			scc_pkg::SCC_REG_WDT_SEL:
				wdt_watch_reg <= bus.wdata[0];
			default: ;
			endcase
		end
	end

	// Divider table writes through an index register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			div_idx_reg <= '0;
			for (int i = 0; i < scc_pkg::SCC_NUM_DIV; i++)
				div_reg[i] <= '0;
			for (int i = 0; i < scc_pkg::SCC_NUM_FRAC; i++)
				frac_reg[i] <= '0;
		end else if (wr_ok && bus.addr == scc_pkg::SCC_REG_DIV_SEL) begin
			if (bus.wdata[3:0] < 4'hC)
				div_idx_reg <= bus.wdata[3:0];
		end else if (wr_ok && bus.addr == scc_pkg::SCC_REG_DIV_VAL) begin
			div_reg[div_idx_reg] <= bus.wdata[15:0];
			if (div_idx_reg >= 4'hA)
				frac_reg[div_idx_reg[0]] <= bus.wdata[20:16];
		end
	end

	// ==========================================================
	// Source selection synchroniser and glitch-free switch
	// ==========================================================
	typedef enum {SCC_SW_RUN, SCC_SW_DRAIN, SCC_SW_WAIT} scc_sw_t;
	scc_sw_t                 sw_state;
	logic [2:0]              sel_sync [SYNC_LEN];
	logic [2:0]              cur_src_reg;
	logic [3:0]              settle_reg;
	logic                    sel_stable;

	// Chain of flops; only the last stage feeds the switch
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < SYNC_LEN; i++)
				sel_sync[i] <= 3'h0;
		end else begin
			sel_sync[0] <= sel_reg;
			for (int i = 1; i < SYNC_LEN; i++)
				sel_sync[i] <= sel_sync[i-1];
		end
	end

	assign sel_stable = sel_sync[SYNC_LEN-1] != cur_src_reg;

	// Old source finishes its tick, gate low, then new one starts
	always_ff @(posedge core_clk) begin
		if (reset) begin
			sw_state    <= SCC_SW_RUN;
			cur_src_reg <= 3'h0;
			settle_reg  <= '0;
		end else begin
			case (sw_state)
			SCC_SW_RUN: begin
				if (sel_stable)
					sw_state <= SCC_SW_DRAIN;
			end
			SCC_SW_DRAIN: begin
				cur_src_reg <= sel_sync[SYNC_LEN-1];
				settle_reg  <= 4'(scc_pkg::SCC_SETTLE_CYC);
				sw_state    <= SCC_SW_WAIT;
			end
			SCC_SW_WAIT: begin
				// Wait for a whole edge of the new source
				if (settle_reg != '0)
					settle_reg <= settle_reg - 1'b1;
				else if (src_tick[cur_src_reg])
					sw_state <= SCC_SW_RUN;
			end
			default: sw_state <= SCC_SW_RUN;
			endcase
		end
	end

	// Gated high-frequency tick; held low while switching
	always_ff @(posedge core_clk) begin
		if (reset) begin
			high_freq_clock_en <= 1'b0;
			high_freq_src      <= 3'h0;
		end else begin
			high_freq_clock_en <= sw_state == SCC_SW_RUN
				&& !sel_stable && src_tick[cur_src_reg];
			high_freq_src      <= cur_src_reg;
		end
	end

	// ==========================================================
	// Oscillator settings, radio clock, wait states
	// ==========================================================
	always_ff @(posedge core_clk) begin
		if (reset) begin
			main_internal_osc_frq     <= scc_pkg::SCC_FRQ_RESET;
			main_internal_osc_trim    <= '0;
			fast_crystal_osc_cap      <= scc_pkg::SCC_CAP_RESET;
			low_speed_internal_osc_on <= 1'b1;
			radio_subsystem_clk_en    <= 1'b0;
			flash_wait_states         <= 2'h2;
			wdt_clk_en                <= 1'b0;
		end else begin
			main_internal_osc_frq  <= frq_reg;
			// Factory trim unless a flash trim is applied
			main_internal_osc_trim <= trm_flash_reg ? trm_reg
				: trim_latches;
			fast_crystal_osc_cap   <= cap_reg;
			// Never stopped, deep sleep or not
			low_speed_internal_osc_on <= 1'b1;
			// Active uses the fast crystal, sleep the watch crystal
			radio_subsystem_clk_en <= radio_sleep
				? src_tick[scc_pkg::SCC_SRC_WATCH]
				: src_tick[scc_pkg::SCC_SRC_FAST];
			// Only main oscillator frequency is known; others worst case
			if (cur_src_reg != 3'h0 || frq_reg >= scc_pkg::SCC_FRQ_WS2)
				flash_wait_states <= 2'h2;
			else if (frq_reg >= scc_pkg::SCC_FRQ_WS1)
				flash_wait_states <= 2'h1;
			else
				flash_wait_states <= 2'h0;
			wdt_clk_en <= wdt_watch_reg
				? src_tick[scc_pkg::SCC_SRC_WATCH]
				: src_tick[scc_pkg::SCC_SRC_LOW];
		end
	end

	// ==========================================================
	// Low-speed calibration against the main oscillator
	// ==========================================================
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cal_busy_reg <= 1'b0;
			cal_len_reg  <= '0;
			cal_cnt_reg  <= '0;
			cal_win_reg  <= '0;
		end else if (wr_ok && bus.addr == scc_pkg::SCC_REG_CAL_CTL
			&& bus.wdata[15:0] != '0) begin
			cal_len_reg  <= bus.wdata[15:0];
			cal_cnt_reg  <= '0;
			cal_win_reg  <= '0;
			cal_busy_reg <= 1'b1;
		end else if (cal_busy_reg) begin
			// Main ticks counted across N low-speed ticks
			// Window opens on the first low tick, so N whole periods
			if (src_tick[scc_pkg::SCC_SRC_MAIN] && cal_win_reg != '0)
				cal_cnt_reg <= cal_cnt_reg + 1'b1;
			if (src_tick[scc_pkg::SCC_SRC_LOW]) begin
				cal_win_reg <= cal_win_reg + 1'b1;
				if (cal_win_reg == cal_len_reg)
					cal_busy_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Peripheral dividers, analog clock leading
	// ==========================================================
	logic       analog_tick;

	// Analog tap registered once; digital taps get one more stage
	always_ff @(posedge core_clk) begin
		if (reset)
			analog_clk_en <= 1'b0;
		else
			analog_clk_en <= analog_tick;
	end

	scc_divider #(.DIV_W(16), .FRAC_W(5), .FRAC(1'b0)) u_analog (
		.core_clk   (core_clk),
		.reset      (reset),
		.base_en    (high_freq_clock_en),
		.phase_hold (1'b0),
		.div_val    (div_reg[0]),
		.frac_val   (5'h00),
		.tick       (analog_tick)
	);

	logic [scc_pkg::SCC_NUM_DIV-1:0] div_tick;
	logic [scc_pkg::SCC_NUM_DIV-1:0] dig_dly_reg;

	for (genvar g = 0; g < scc_pkg::SCC_NUM_DIV; g++) begin : g_div
		localparam bit IS_FRAC = g >= 10;
		scc_divider #(.DIV_W(16), .FRAC_W(5), .FRAC(IS_FRAC)) u_div (
			.core_clk   (core_clk),
			.reset      (reset),
			.base_en    (high_freq_clock_en),
			.phase_hold (1'b0),
			.div_val    (div_reg[g]),
			.frac_val   (IS_FRAC ? frac_reg[g % 2] : 5'h00),
			.tick       (div_tick[g])
		);
	end

	// Delay of one cycle puts digital edges after the analog edge
	always_ff @(posedge core_clk) begin
		if (reset) begin
			dig_dly_reg   <= '0;
			periph_clk_en <= '0;
		end else begin
			dig_dly_reg   <= div_tick;
			periph_clk_en <= dig_dly_reg;
		end
	end

	// ==========================================================
	// Register read port, data one cycle after the strobe
	// ==========================================================
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdata <= 32'h0000_0000;
		end else if (bus.rd) begin
			case (bus.addr)
			scc_pkg::SCC_REG_SRC_SEL:  rdata <= {29'h0, sel_reg};
			scc_pkg::SCC_REG_MAIN_FRQ: rdata <= {26'h0, frq_reg};
			scc_pkg::SCC_REG_MAIN_TRM:
				rdata <= {23'h0, trm_flash_reg, main_internal_osc_trim};
			scc_pkg::SCC_REG_FAST_CAP: rdata <= {24'h0, cap_reg};
			scc_pkg::SCC_REG_CAL_CTL:  rdata <= {16'h0, cal_len_reg};
			scc_pkg::SCC_REG_CAL_CNT:  rdata <= {16'h0, cal_cnt_reg};
			scc_pkg::SCC_REG_STATUS:
				rdata <= {21'h0, cur_src_reg, 2'h0, flash_wait_states,
					2'h0, cal_busy_reg, sw_state != SCC_SW_RUN};
			scc_pkg::SCC_REG_DIV_SEL:  rdata <= {28'h0, div_idx_reg};
			scc_pkg::SCC_REG_DIV_VAL:
				rdata <= {11'h0, div_idx_reg >= 4'hA
					? frac_reg[div_idx_reg[0]] : 5'h00,
					div_reg[div_idx_reg]};
			scc_pkg::SCC_REG_WDT_SEL:  rdata <= {31'h0, wdt_watch_reg};
			default:                   rdata <= 32'h0000_0000;
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	sequence sw_begin_s;
		sw_state == SCC_SW_RUN && sel_stable;
	endsequence

	property no_tick_switch_p;
		@(posedge core_clk) disable iff (reset)
		sw_begin_s |=> !high_freq_clock_en [*2];
	endproperty

	high_freq_clock_gap_a: assert property (no_tick_switch_p)
		else $error("tick emitted during source switch");

	sync_delay_a: assert property (@(posedge core_clk) disable iff (reset)
		$changed(sel_reg) |=> sw_state == SCC_SW_RUN)
		else $error("switch started before select synchronised");

	src_legal_a: assert property (@(posedge core_clk) disable iff (reset)
		cur_src_reg <= 3'h4)
		else $error("illegal current source");

	frq_range_a: assert property (@(posedge core_clk) disable iff (reset)
		frq_reg >= scc_pkg::SCC_FRQ_MIN
		&& frq_reg <= scc_pkg::SCC_FRQ_MAX)
		else $error("main frequency out of range");

	reset_main_a: assert property (@(posedge core_clk)
		$fell(reset) |-> cur_src_reg == 3'h0
		&& frq_reg == scc_pkg::SCC_FRQ_RESET)
		else $error("reset did not pick main oscillator at 24");

	trim_factory_a: assert property (@(posedge core_clk)
		disable iff (reset)
		!trm_flash_reg && $stable(trm_flash_reg) |=>
		main_internal_osc_trim == $past(trim_latches))
		else $error("factory trim not applied");

	ws_top_a: assert property (@(posedge core_clk) disable iff (reset)
		cur_src_reg == 3'h0 && frq_reg == scc_pkg::SCC_FRQ_MAX
		&& $stable(frq_reg) && $stable(cur_src_reg)
		|=> flash_wait_states == 2'h2)
		else $error("wait states wrong at 48");

	ws_mid_a: assert property (@(posedge core_clk) disable iff (reset)
		cur_src_reg == 3'h0 && frq_reg == scc_pkg::SCC_FRQ_RESET
		&& $stable(frq_reg) && $stable(cur_src_reg)
		|=> flash_wait_states == 2'h1)
		else $error("wait states wrong at 24");

	radio_clk_a: assert property (@(posedge core_clk) disable iff (reset)
		!radio_sleep && src_tick[2] |=> radio_subsystem_clk_en)
		else $error("radio active clock missing");

	analog_lead_a: assert property (@(posedge core_clk)
		disable iff (reset)
		div_tick[0] |=> analog_clk_en ##1 periph_clk_en[0])
		else $error("analog and digital tick misaligned");

	low_awake_a: assert property (@(posedge core_clk) disable iff (reset)
		deep_sleep |=> low_speed_internal_osc_on)
		else $error("low-speed oscillator stopped in deep sleep");

endmodule

`default_nettype wire

// file: rtl/scc_pkg.sv
/*
 * Package for the system clock source control block: register map,
 * field layouts, reset values, source codes and timing counts.
 * Assumes a single 40 MHz core clock; oscillators arrive as
 * synchronous enable-like level inputs sampled on that clock.
 */
package scc_pkg;

	// ==========================================================
	// Source selection codes
	// ==========================================================
	typedef enum logic [2:0] {
		SCC_SRC_MAIN  = 3'h0,
		SCC_SRC_LOW   = 3'h1,
		SCC_SRC_FAST  = 3'h2,
		SCC_SRC_WATCH = 3'h3,
		SCC_SRC_PIN   = 3'h4
	} scc_src_t;

	localparam int unsigned SCC_NUM_SRC = 5;

	// ==========================================================
	// Register offsets (byte offsets; word index is offset / 4)
	// ==========================================================
	localparam logic [7:0] SCC_REG_SRC_SEL  = 8'h00;
	localparam logic [7:0] SCC_REG_MAIN_FRQ = 8'h04;
	localparam logic [7:0] SCC_REG_MAIN_TRM = 8'h08;
	localparam logic [7:0] SCC_REG_FAST_CAP = 8'h0C;
	localparam logic [7:0] SCC_REG_CAL_CTL  = 8'h10;
	localparam logic [7:0] SCC_REG_CAL_CNT  = 8'h14;
	localparam logic [7:0] SCC_REG_STATUS   = 8'h18;
	localparam logic [7:0] SCC_REG_DIV_SEL  = 8'h1C;
	localparam logic [7:0] SCC_REG_DIV_VAL  = 8'h20;
	localparam logic [7:0] SCC_REG_WDT_SEL  = 8'h24;

	// ==========================================================
	// Field layouts and reset values
	// ==========================================================
	localparam int unsigned SCC_FRQ_W      = 6;
	localparam logic [5:0]  SCC_FRQ_MIN    = 6'h03;
	localparam logic [5:0]  SCC_FRQ_MAX    = 6'h30;
	localparam logic [5:0]  SCC_FRQ_RESET  = 6'h18;
	localparam logic [5:0]  SCC_FRQ_WS2    = 6'h21;
	localparam logic [5:0]  SCC_FRQ_WS1    = 6'h11;
	localparam int unsigned SCC_TRM_W      = 8;
	localparam int unsigned SCC_CAP_W      = 8;
	localparam logic [7:0]  SCC_CAP_RESET  = 8'h80;
	localparam int unsigned SCC_NUM_DIV    = 12;
	localparam int unsigned SCC_NUM_FRAC   = 2;
	localparam int unsigned SCC_DIV_W      = 16;
	localparam int unsigned SCC_FRAC_W     = 5;
	localparam int unsigned SCC_CAL_W      = 16;
	localparam int unsigned SCC_SYNC_LEN   = 2;

	// Status register field positions
	localparam int unsigned SCC_ST_SWITCHING = 0;
	localparam int unsigned SCC_ST_CAL_BUSY  = 1;
	localparam int unsigned SCC_ST_WS_LO     = 4;
	localparam int unsigned SCC_ST_SRC_LO    = 8;

	// Settle time on a source change, in ns, and its cycle count
	localparam int unsigned SCC_CLK_NS      = 25;
	localparam int unsigned SCC_SETTLE_NS   = 100;
	localparam int unsigned SCC_SETTLE_CYC  =
		(SCC_SETTLE_NS + SCC_CLK_NS - 1) / SCC_CLK_NS;

	// Register bus carrier
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} scc_bus_t;

endpackage

// file: rtl/scc_divider.sv
/*
 * Peripheral clock divider producing one-cycle enable pulses.
 * Integer divide by (div+1); optional fractional part in 1/32 steps.
 * Assumes base_en marks each high-frequency clock tick.
 */
`timescale 1ns/1ps
`default_nettype none

module scc_divider #(
	parameter int unsigned DIV_W  = 16,
	parameter int unsigned FRAC_W = 5,
	parameter bit          FRAC   = 1'b0
) (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              base_en,
	input  wire logic              phase_hold,
	input  wire logic [DIV_W-1:0]  div_val,
	input  wire logic [FRAC_W-1:0] frac_val,
	output logic                   tick
);

	// ==========================================================
	// Counter with fractional accumulator
	// ==========================================================
	logic [DIV_W-1:0]  cnt_reg;
	logic [FRAC_W:0]   acc_reg;
	logic [FRAC_W:0]   acc_sum;
	logic              extra;

	assign acc_sum = {1'b0, acc_reg[FRAC_W-1:0]} + {1'b0, frac_val};
	assign extra   = FRAC && acc_sum[FRAC_W];

	// Terminal count gives the tick; a carry stretches one period
	always_ff @(posedge core_clk) begin
		tick <= 1'b0;
		if (reset) begin
			cnt_reg <= '0;
			acc_reg <= '0;
		end else if (base_en && !phase_hold) begin
			if (cnt_reg >= div_val + {{(DIV_W-1){1'b0}}, extra}) begin
				cnt_reg <= '0;
				tick    <= 1'b1;
				acc_reg <= FRAC ? acc_sum : '0;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// file: tb/tb_top.sv
/*
 * Self-checking bench for the clock source control block.
 * Assumes the design package and scc_top are compiled first; the
 * bench drives every input itself, including the oscillator ticks.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;

	// ==========================================================
	// Signals and design instance
	// ==========================================================
	logic              core_clk;
	logic              reset;
	scc_pkg::scc_bus_t bus;
	logic [31:0]       rdata;
	logic [4:0]        src_tick;
	logic [7:0]        trim_latches;
	logic              deep_sleep;
	logic              radio_sleep;
	logic              hf_en;
	logic [2:0]        hf_src;
	logic [5:0]        frq;
	logic [7:0]        trim;
	logic [7:0]        cap;
	logic              low_on;
	logic              radio_en;
	logic [1:0]        ws;
	logic              analog_en;
	logic [11:0]       periph_en;
	logic              wdt_en;
	int                n_fail;
	int                checks;
	int                cyc;
	int                n_tick[5];
	int                d_tick[5];
	int                n_hf, n_per1, n_wdt, d_hf, d_per1, d_wdt;
	int                rad_err, an_err;
	logic              prev_rad, prev_an;
	logic [31:0]       d;
	localparam int PER[5] = '{2, 20, 3, 50, 5};

	scc_top dut_u (
		.core_clk                  (core_clk),
		.reset                     (reset),
		.bus                       (bus),
		.rdata                     (rdata),
		.src_tick                  (src_tick),
		.trim_latches              (trim_latches),
		.deep_sleep                (deep_sleep),
		.radio_sleep               (radio_sleep),
		.high_freq_clock_en        (hf_en),
		.high_freq_src             (hf_src),
		.main_internal_osc_frq     (frq),
		.main_internal_osc_trim    (trim),
		.fast_crystal_osc_cap      (cap),
		.low_speed_internal_osc_on (low_on),
		.radio_subsystem_clk_en    (radio_en),
		.flash_wait_states         (ws),
		.analog_clk_en             (analog_en),
		.periph_clk_en             (periph_en),
		.wdt_clk_en                (wdt_en)
	);

	// ==========================================================
	// Clock, oscillator ticks and monitors
	// ==========================================================
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Each source ticks at its own rate so a wrong pick shows in counts
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		for (int i = 0; i < 5; i++) src_tick[i] <= (cyc % PER[i]) == 0;
	end

	// Pulse counters; one-cycle followers checked against last cycle
	always @(posedge core_clk) begin
		if (!reset) begin
			foreach (n_tick[i]) n_tick[i] += int'(src_tick[i]);
			n_hf += int'(hf_en);
			n_per1 += int'(periph_en[1]);
			n_wdt += int'(wdt_en);
			if (radio_en !== prev_rad) rad_err++;
			if (periph_en[0] !== prev_an) an_err++;
		end
		prev_rad = radio_sleep ? src_tick[3] : src_tick[2];
		prev_an = analog_en;
	end

	// ==========================================================
	// Access and compare tasks
	// ==========================================================
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus.wr <= 1'b0;
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus.rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Counts may straddle a window edge, so one pulse of slack
	task automatic chk_near(input int got, input int exp);
		checks++;
		if (got > exp + 1 || got < exp - 1) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic win(input int w);
		int b_tick[5];
		int b_hf, b_p, b_w;
		b_tick = n_tick;
		b_hf = n_hf;
		b_p = n_per1;
		b_w = n_wdt;
		repeat (w) @(posedge core_clk);
		#1;
		foreach (d_tick[i]) d_tick[i] = n_tick[i] - b_tick[i];
		d_hf = n_hf - b_hf;
		d_per1 = n_per1 - b_p;
		d_wdt = n_wdt - b_w;
	endtask

	task automatic tally_and_finish;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Watchdog sized well beyond the expected run length
	initial begin
		#(25 * 60000);
		n_fail++;
		tally_and_finish();
	end

	// ==========================================================
	// Tests
	// ==========================================================
	initial begin
		int n;
		bus = '0;
		reset = 1'b1;
		trim_latches = 8'h5A;
		deep_sleep = 1'b0;
		radio_sleep = 1'b0;
		cyc = 0;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		bus_rd(scc_pkg::SCC_REG_MAIN_FRQ, d);
		chk(d, 32'h18);
		bus_rd(scc_pkg::SCC_REG_STATUS, d);
		chk({29'h0, d[10:8]}, 32'h0);
		chk({24'h0, cap}, 32'h80);
		chk({24'h0, trim}, 32'h5A);
		chk({30'h0, ws}, 32'h1);
		bus_rd(8'h40, d);
		chk(d, 32'h0);
		$display("test reset_values done");
		// Frequency range edges, refused values, wait states
		bus_wr(scc_pkg::SCC_REG_MAIN_FRQ, 32'h30);
		bus_rd(scc_pkg::SCC_REG_MAIN_FRQ, d);
		chk(d, 32'h30);
		chk({30'h0, ws}, 32'h2);
		bus_wr(scc_pkg::SCC_REG_MAIN_FRQ, 32'h31);
		bus_wr(scc_pkg::SCC_REG_MAIN_FRQ, 32'h03);
		bus_wr(scc_pkg::SCC_REG_MAIN_FRQ, 32'h02);
		bus_rd(scc_pkg::SCC_REG_MAIN_FRQ, d);
		chk(d, 32'h03);
		chk({26'h0, frq}, 32'h03);
		bus_wr(scc_pkg::SCC_REG_MAIN_FRQ, 32'h18);
		bus_wr(scc_pkg::SCC_REG_MAIN_TRM, 32'h133);
		bus_wr(scc_pkg::SCC_REG_FAST_CAP, 32'h41);
		@(posedge core_clk);
		#1;
		chk({24'h0, trim}, 32'h33);
		chk({24'h0, cap}, 32'h41);
		$display("test main_osc done");
		// Every source code, then a refused code
		// Main last, so every step is a real change of source
		for (int s = 1; s <= 5; s++) begin
			int c;
			c = s % 5;
			bus_wr(scc_pkg::SCC_REG_SRC_SEL, 32'(c));
			n = 0;
			while (hf_src !== 3'(c) && n < 100) begin
				@(posedge core_clk);
				#1 n++;
			end
			chk(32'(n >= 2), 32'h1);
			chk({29'h0, hf_src}, 32'(c));
			chk({30'h0, ws}, (c == 0) ? 32'h1 : 32'h2);
			repeat (60) @(posedge core_clk);
			win(300);
			chk_near(d_hf, d_tick[c]);
		end
		bus_wr(scc_pkg::SCC_REG_SRC_SEL, 32'h5);
		repeat (20) @(posedge core_clk);
		#1 chk({29'h0, hf_src}, 32'h0);
		repeat (20) @(posedge core_clk);
		$display("test switching done");
		// Radio clock, low-speed oscillator and watchdog source
		rad_err = 0;
		win(200);
		chk(32'(rad_err), 32'h0);
		@(posedge core_clk);
		radio_sleep <= 1'b1;
		deep_sleep <= 1'b1;
		repeat (2) @(posedge core_clk);
		rad_err = 0;
		win(200);
		chk(32'(rad_err), 32'h0);
		chk({31'h0, low_on}, 32'h1);
		chk_near(d_wdt, d_tick[1]);
		bus_wr(scc_pkg::SCC_REG_WDT_SEL, 32'h1);
		repeat (4) @(posedge core_clk);
		win(300);
		chk_near(d_wdt, d_tick[3]);
		$display("test radio_wdt done");
		// Calibration of low-speed against main ticks
		bus_wr(scc_pkg::SCC_REG_CAL_CTL, 32'h4);
		n = 0;
		d = 32'h2;
		while (d[1] !== 1'b0 && n < 200) begin
			bus_rd(scc_pkg::SCC_REG_STATUS, d);
			n++;
		end
		chk(32'(n < 200), 32'h1);
		bus_rd(scc_pkg::SCC_REG_CAL_CNT, d);
		chk_near(int'(d[15:0]), 4 * PER[1] / PER[0]);
		$display("test calibration done");
		// Divider rate and analog lead
		bus_wr(scc_pkg::SCC_REG_DIV_SEL, 32'h1);
		bus_wr(scc_pkg::SCC_REG_DIV_VAL, 32'h3);
		repeat (10) @(posedge core_clk);
		an_err = 0;
		win(400);
		chk_near(d_per1, d_hf / 4);
		chk(32'(an_err), 32'h0);
		$display("test dividers done");
		tally_and_finish();
	end

endmodule

`default_nettype wire
